/* core/pump_ctrl_pkg.sv */
// Package: constants and types for the pump control mode logic
package pump_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map (word aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CIN0   = 8'h04;
  localparam logic [7:0] ADDR_CIN1   = 8'h08;
  localparam logic [7:0] ADDR_LEVEL0 = 8'h0C;
  localparam logic [7:0] ADDR_LEVEL1 = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB  = 0;   // 2 bits: configured mode
  localparam int CTRL_COMBINED  = 2;   // 1: combined evaluation
  localparam int CTRL_TWO_INPUT = 3;   // 1: two control inputs used
  localparam int CTRL_REMOTE    = 4;   // remote run command
  localparam int CIN_SRC_ANALOG = 0;   // 1: analog value source
  localparam int CIN_NEGATIVE   = 1;   // 1: negative polarity
  localparam int CIN_CHAN_LSB   = 4;   // 2 bits: channel select
  localparam int CIN_HYST_LSB   = 8;   // 7 bits: hysteresis percent

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int NUM_ANALOG   = 4;
  localparam int NUM_SWITCH   = 4;
  localparam int NUM_LOCAL    = 1;
  localparam int VALUE_W      = 16;
  localparam int HYST_W       = 7;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] CIN_RESET   = 32'h0000_0000;
  localparam logic [31:0] LEVEL_RESET = 32'h0000_0000;
  localparam logic [6:0]  PERCENT_DIV = 7'h64;

  typedef enum logic [1:0] {
    CFG_REMOTE     = 2'h0,
    CFG_AUTONOMOUS = 2'h1,
    CFG_LOCAL      = 2'h2
  } cfg_mode_t;

  typedef enum logic [2:0] {
    ST_REMOTE     = 3'b001,
    ST_AUTONOMOUS = 3'b010,
    ST_LOCAL      = 3'b100
  } op_state_t;

endpackage

/* core/pv_control_input.sv */
// One process-variable control input with hysteresis and polarity
`timescale 1ns/1ps
module pv_control_input
  import pump_ctrl_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic               src_analog_i,
  input  wire logic               negative_i,
  input  wire logic [HYST_W-1:0]  hyst_pct_i,
  input  wire logic [VALUE_W-1:0] level_i,
  input  wire logic [VALUE_W-1:0] value_i,
  input  wire logic               switch_i,
  output logic                    run_o
);

  logic [VALUE_W+HYST_W-1:0] prod;
  logic [VALUE_W:0]          band;
  logic [VALUE_W+1:0]        upper;
  logic [VALUE_W+1:0]        lower;
  logic                      above_q;
  logic                      above_d;
  logic                      raw;

  // ----------------------------------------------------------------
  // Thresholds
  // ----------------------------------------------------------------
  assign prod  = level_i * hyst_pct_i;
  // Band may exceed the level above 100 percent; widths avoid a wrap
  assign band  = (VALUE_W+1)'(prod / PERCENT_DIV);
  assign upper = {2'b00, level_i} + {1'b0, band};
  // Lower threshold may go negative; a sign bit keeps compare correct
  assign lower = {2'b00, level_i} - {1'b0, band};

  // A threshold change also flips state once the value lies beyond the new threshold
  always_comb begin
    above_d = above_q;
    if ({2'b00, value_i} > upper) begin
      above_d = 1'b1;
    end else if (!lower[VALUE_W+1] && {2'b00, value_i} < lower) begin
      above_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      above_q <= 1'b0;
    end else begin
      above_q <= above_d;
    end
  end

  assign raw   = src_analog_i ? above_q : switch_i;
  assign run_o = negative_i ? ~raw : raw;

endmodule

/* core/pump_control_mode_logic.sv */
// Pump control mode selection with Wishbone register access
//
// Functional notes
// - Analog channels carry sensor values, switch channels carry on/off levels.
// - While bypass is on, detected trips are ignored and operation continues.
// - Manual override takes commands from local inputs as in local mode.
// - Under override the pump runs only with control input conditions met.
// - Three modes: remote, autonomous, local each pick the command source.
// - Autonomous uses one or two inputs, each analog or switch sourced.
// - In autonomous mode degraded status affects nothing.
// - In local mode run needs local command and control conditions met.
// - Remote falls to local on degraded or override, returns when both clear.
// - Autonomous falls to local on override, returns on release.
// - Each input has a source and a polarity selection.
// - Analog inputs use level plus and minus a hysteresis percentage.
// - Hysteresis changes take effect at once on the thresholds and can flip state.
// - Positive polarity runs above upper or on high switch.
// - Negative polarity inverts the positive result.
// - Separate evaluation runs when any input reports on.
// - Combined evaluation runs only when both inputs request run.
`timescale 1ns/1ps
module pump_control_mode_logic
  import pump_ctrl_pkg::*;
(
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_i,
  // Wishbone classic slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [7:0]                    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  output logic                               wb_err_o,
  // Field side
  input  wire logic [NUM_ANALOG*VALUE_W-1:0] process_variable_i,
  input  wire logic [NUM_SWITCH-1:0]         process_switch_i,
  input  wire logic [NUM_LOCAL-1:0]          local_run_i,
  input  wire logic                          manual_override_i,
  input  wire logic                          bypass_i,
  input  wire logic                          degraded_i,
  input  wire logic                          trip_i,
  output logic                               pump_run_o,
  output logic                               trip_o,
  output logic [2:0]                         op_state_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [NUM_ANALOG*VALUE_W-1:0] pv_s1_q;
  logic [NUM_ANALOG*VALUE_W-1:0] pv_s2_q;
  logic [NUM_SWITCH-1:0]         sw_s1_q;
  logic [NUM_SWITCH-1:0]         sw_s2_q;
  logic [4:0]                    misc_s1_q;
  logic [4:0]                    misc_s2_q;
  logic                          local_run;
  logic                          override;
  logic                          bypass;
  logic                          degraded;
  logic                          trip;

  // Analog words are assumed held stable by the I/O module between
  // updates; per-bit sync of a moving word could tear a sample.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pv_s1_q <= '0;
      pv_s2_q <= '0;
    end else begin
      pv_s1_q <= process_variable_i;
      pv_s2_q <= pv_s1_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sw_s1_q <= '0;
      sw_s2_q <= '0;
    end else begin
      sw_s1_q <= process_switch_i;
      sw_s2_q <= sw_s1_q;
    end
  end

  // Order: local run, override, bypass, degraded, trip
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      misc_s1_q <= '0;
      misc_s2_q <= '0;
    end else begin
      misc_s1_q <= {local_run_i[0], manual_override_i, bypass_i,
                    degraded_i, trip_i};
      misc_s2_q <= misc_s1_q;
    end
  end

  assign local_run = misc_s2_q[4];
  assign override  = misc_s2_q[3];
  assign bypass    = misc_s2_q[2];
  assign degraded  = misc_s2_q[1];
  assign trip      = misc_s2_q[0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] cin_q   [2];
  logic [31:0] level_q [2];
  logic        wb_req;
  logic        wr_en;
  logic        addr_ok;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign addr_ok = (wb_adr_i == ADDR_CTRL)   || (wb_adr_i == ADDR_CIN0) ||
                   (wb_adr_i == ADDR_CIN1)   ||
                   (wb_adr_i == ADDR_LEVEL0) ||
                   (wb_adr_i == ADDR_LEVEL1) ||
                   (wb_adr_i == ADDR_STATUS);
  assign wr_en  = wb_req && wb_we_i && addr_ok;

  // Unselected byte lanes keep their old contents
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en && wb_adr_i == ADDR_CTRL) begin
      ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cin_q[0] <= CIN_RESET;
      cin_q[1] <= CIN_RESET;
    end else if (wr_en) begin
      case (wb_adr_i)
        ADDR_CIN0: begin
          cin_q[0] <= merge(cin_q[0], wb_dat_i, wb_sel_i);
        end
        ADDR_CIN1: begin
          cin_q[1] <= merge(cin_q[1], wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      level_q[0] <= LEVEL_RESET;
      level_q[1] <= LEVEL_RESET;
    end else if (wr_en) begin
      case (wb_adr_i)
        ADDR_LEVEL0: begin
          level_q[0] <= merge(level_q[0], wb_dat_i, wb_sel_i);
        end
        ADDR_LEVEL1: begin
          level_q[1] <= merge(level_q[1], wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control inputs
  // ----------------------------------------------------------------
  logic [1:0] cin_run;

  for (genvar g = 0; g < 2; g++) begin : g_cin
    logic [1:0]         chan;
    logic [VALUE_W-1:0] value;
    logic               sw;
    assign chan  = cin_q[g][CIN_CHAN_LSB +: 2];
    assign value = pv_s2_q[chan*VALUE_W +: VALUE_W];
    assign sw    = sw_s2_q[chan];
    pv_control_input u_cin (
      .core_clk_i   (core_clk_i),
      .rst_i        (rst_i),
      .src_analog_i (cin_q[g][CIN_SRC_ANALOG]),
      .negative_i   (cin_q[g][CIN_NEGATIVE]),
      .hyst_pct_i   (cin_q[g][CIN_HYST_LSB +: HYST_W]),
      .level_i      (level_q[g][VALUE_W-1:0]),
      .value_i      (value),
      .switch_i     (sw),
      .run_o        (cin_run[g])
    );
  end

  logic two_inputs;
  logic cond_ok;

  assign two_inputs = ctrl_q[CTRL_TWO_INPUT];

  always_comb begin
    if (!two_inputs) begin
      cond_ok = cin_run[0];
    end else if (ctrl_q[CTRL_COMBINED]) begin
      cond_ok = cin_run[0] && cin_run[1];
    end else begin
      cond_ok = cin_run[0] || cin_run[1];
    end
  end

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  cfg_mode_t cfg_mode;
  op_state_t state_q;
  op_state_t state_d;

  assign cfg_mode = cfg_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);

  always_comb begin
    case (cfg_mode)
      CFG_REMOTE: begin
        state_d = (degraded || override) ? ST_LOCAL : ST_REMOTE;
      end
      CFG_AUTONOMOUS: begin
        // Degraded status deliberately not consulted here
        state_d = override ? ST_LOCAL : ST_AUTONOMOUS;
      end
      CFG_LOCAL: begin
        state_d = ST_LOCAL;
      end
      // Spare mode code falls back to local control
      default: begin
        state_d = ST_LOCAL;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= ST_REMOTE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Run command and trip handling
  // ----------------------------------------------------------------
  logic run_d;

  always_comb begin
    case (state_q)
      ST_REMOTE: begin
        run_d = ctrl_q[CTRL_REMOTE];
      end
      ST_AUTONOMOUS: begin
        run_d = cond_ok;
      end
      // Override lands here too, so both need the input conditions
      ST_LOCAL: begin
        run_d = local_run && cond_ok;
      end
      default: begin
        run_d = 1'b0;
      end
    endcase
    // Trip gate sits after the mode choice so no source escapes it
    if (trip && !bypass) begin
      run_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pump_run_o <= 1'b0;
      trip_o     <= 1'b0;
      op_state_o <= ST_REMOTE;
    end else begin
      pump_run_o <= run_d;
      trip_o     <= trip && !bypass;
      op_state_o <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  logic [31:0] rd_data;

  always_comb begin
    case (wb_adr_i)
      ADDR_CTRL: begin
        rd_data = ctrl_q;
      end
      ADDR_CIN0: begin
        rd_data = cin_q[0];
      end
      ADDR_CIN1: begin
        rd_data = cin_q[1];
      end
      ADDR_LEVEL0: begin
        rd_data = level_q[0];
      end
      ADDR_LEVEL1: begin
        rd_data = level_q[1];
      end
      // Live view: state, bypass, trip, run, condition, input runs
      ADDR_STATUS: begin
        rd_data = {23'h00_0000, cin_run, cond_ok,
                   pump_run_o, trip_o, bypass, state_q};
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // The ack term in wb_req keeps a held strobe from a second take

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req && addr_ok;
      wb_err_o <= wb_req && !addr_ok;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : 32'h0000_0000;
    end
  end

endmodule

/* testbench/pump_control_mode_logic_monitor.sv */
// Checker: port-level assertions for the pump control mode logic
`timescale 1ns/1ps
module pump_control_mode_logic_monitor
  import pump_ctrl_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_o,
  input  wire logic        wb_err_o,
  input  wire logic        manual_override_i,
  input  wire logic        bypass_i,
  input  wire logic        degraded_i,
  input  wire logic        trip_i,
  input  wire logic        pump_run_o,
  input  wire logic        trip_o,
  input  wire logic [2:0]  op_state_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Shadow of the mode word; lags the design by one cycle on purpose
  // ----------------------------------------------------------------
  logic [1:0] cfg_q;
  logic       rrun_q;
  logic       req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_q  <= 2'h0;
      rrun_q <= 1'h0;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == ADDR_CTRL
                 && wb_sel_i[0]) begin
      cfg_q  <= wb_dat_i[1:0];
      rrun_q <= wb_dat_i[CTRL_REMOTE];
    end
  end
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  a_err_unmapped: assert property (req && wb_adr_i > ADDR_STATUS |=>
    wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
  a_bypass_no_trip: assert property (bypass_i [*4] |-> !trip_o)
    else $error("trip shown while bypassed");
  a_trip_seen: assert property (
    (trip_i && !bypass_i) [*4] |-> trip_o)
    else $error("trip not shown");
  a_trip_stops: assert property (
    (trip_i && !bypass_i) [*5] |-> !pump_run_o)
    else $error("pump runs during trip");
  a_override_local: assert property (
    manual_override_i [*4] |-> op_state_o == ST_LOCAL)
    else $error("override did not select local");
  a_degraded_local: assert property (
    (cfg_q == CFG_REMOTE && degraded_i) [*4] |-> op_state_o == ST_LOCAL)
    else $error("degraded remote not local");
  a_remote_return: assert property ((cfg_q == CFG_REMOTE && !degraded_i
    && !manual_override_i) [*4] |-> op_state_o == ST_REMOTE)
    else $error("remote state not restored");
  a_auto_keeps: assert property ((cfg_q == CFG_AUTONOMOUS
    && !manual_override_i) [*4] |-> op_state_o == ST_AUTONOMOUS)
    else $error("autonomous state left");
  a_remote_run: assert property ((cfg_q == CFG_REMOTE && !degraded_i
    && !manual_override_i && !trip_i && $stable(rrun_q)) [*5]
    |-> pump_run_o == rrun_q) else $error("remote command not followed");
  c_local_run: cover property (op_state_o == ST_LOCAL && pump_run_o);
  c_err: cover property (wb_err_o);
  c_bypass_run: cover property (bypass_i && trip_i && pump_run_o);
endmodule

bind pump_control_mode_logic pump_control_mode_logic_monitor
  pump_control_mode_logic_monitor_i (
    .core_clk_i        (core_clk_i),
    .rst_i             (rst_i),
    .wb_cyc_i          (wb_cyc_i),
    .wb_stb_i          (wb_stb_i),
    .wb_we_i           (wb_we_i),
    .wb_adr_i          (wb_adr_i),
    .wb_sel_i          (wb_sel_i),
    .wb_dat_i          (wb_dat_i),
    .wb_ack_o          (wb_ack_o),
    .wb_err_o          (wb_err_o),
    .manual_override_i (manual_override_i),
    .bypass_i          (bypass_i),
    .degraded_i        (degraded_i),
    .trip_i            (trip_i),
    .pump_run_o        (pump_run_o),
    .trip_o            (trip_o),
    .op_state_o        (op_state_o)
  );

/* testbench/field_model.sv */
// Field side model: sensors, process switches and operator inputs
`timescale 1ns/1ps
module field_model
  import pump_ctrl_pkg::*;
(
  input  wire logic                          core_clk_i,
  output logic [NUM_ANALOG*VALUE_W-1:0] process_variable_o,
  output logic [NUM_SWITCH-1:0]         process_switch_o,
  output logic [NUM_LOCAL-1:0]          local_run_o,
  output logic                          override_o,
  output logic                          bypass_o,
  output logic                          degraded_o,
  output logic                          trip_det_o
);
  initial begin
    process_variable_o = '0;
    process_switch_o = '0;
    {local_run_o, override_o, bypass_o, degraded_o, trip_det_o} = '0;
  end
  // ----------------------------------------------------------------
  // Plant changes land just after an edge, like a sampled field bus
  // ----------------------------------------------------------------
  task automatic set_pv(input int ch, input logic [VALUE_W-1:0] v);
    @(posedge core_clk_i);
    process_variable_o[ch*VALUE_W +: VALUE_W] <= v;
  endtask
  task automatic set_sw(input logic [NUM_SWITCH-1:0] v);
    @(posedge core_clk_i);
    process_switch_o <= v;
  endtask
  // Order: local run, override, bypass, degraded, trip
  task automatic set_ops(input logic [4:0] v);
    @(posedge core_clk_i);
    {local_run_o, override_o, bypass_o, degraded_o, trip_det_o} <= v;
  endtask
endmodule

/* testbench/pump_control_mode_logic_tb_top.sv */
// Testbench: register access and mode/run scenarios for the pump logic
`timescale 1ns/1ps
module pump_control_mode_logic_tb_top
  import pump_ctrl_pkg::*;
;
  logic                          core_clk_i = 1'h0;
  logic                          rst_i = 1'h1;
  logic                          wb_cyc_i = 1'h0;
  logic                          wb_stb_i = 1'h0;
  logic                          wb_we_i = 1'h0;
  logic [7:0]                    wb_adr_i = 8'h00;
  logic [3:0]                    wb_sel_i = 4'hF;
  logic [31:0]                   wb_dat_i = 32'h0000_0000;
  logic [31:0]                   wb_dat_o;
  logic                          wb_ack_o, wb_err_o, pump_run_o, trip_o;
  logic [2:0]                    op_state_o;
  logic [NUM_ANALOG*VALUE_W-1:0] process_variable_i;
  logic [NUM_SWITCH-1:0]         process_switch_i;
  logic [NUM_LOCAL-1:0]          local_run_i;
  logic                          manual_override_i, bypass_i;
  logic                          degraded_i, trip_i;
  logic [31:0]                   rd;
  logic                          er;
  int                            failures = 0;
  int                            checked = 0;

  always #50 core_clk_i = ~core_clk_i;

  pump_control_mode_logic pump_control_mode_logic_i (
    .core_clk_i         (core_clk_i),
    .rst_i              (rst_i),
    .wb_cyc_i           (wb_cyc_i),
    .wb_stb_i           (wb_stb_i),
    .wb_we_i            (wb_we_i),
    .wb_adr_i           (wb_adr_i),
    .wb_sel_i           (wb_sel_i),
    .wb_dat_i           (wb_dat_i),
    .wb_dat_o           (wb_dat_o),
    .wb_ack_o           (wb_ack_o),
    .wb_err_o           (wb_err_o),
    .process_variable_i (process_variable_i),
    .process_switch_i   (process_switch_i),
    .local_run_i        (local_run_i),
    .manual_override_i  (manual_override_i),
    .bypass_i           (bypass_i),
    .degraded_i         (degraded_i),
    .trip_i             (trip_i),
    .pump_run_o         (pump_run_o),
    .trip_o             (trip_o),
    .op_state_o         (op_state_o)
  );
  field_model field_model_i (
    .core_clk_i         (core_clk_i),
    .process_variable_o (process_variable_i),
    .process_switch_o   (process_switch_i),
    .local_run_o        (local_run_i),
    .override_o         (manual_override_i),
    .bypass_o           (bypass_i),
    .degraded_o         (degraded_i),
    .trip_det_o         (trip_i)
  );
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request stands until ack or err is sampled high at a rising edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 50);
    rd = wb_dat_o;
    er = wb_err_o;
    if (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1) begin
      failures++;
      results();
    end
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e,
                       input string nm);
    wb(1'h0, a, 32'h0000_0000);
    chk(nm, rd & m, e);
  endtask
  // Field effects land within five edges of a change
  task automatic settle();
    repeat (6) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask
  task automatic pv(input logic [15:0] v, input logic e);
    field_model_i.set_pv(0, v);
    settle();
    chk("pump run", pump_run_o, e);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdchk(ADDR_CTRL, 32'hFFFF_FFFF, CTRL_RESET, "ctrl reset");
    rdchk(ADDR_STATUS, 32'h0000_0007, 32'h0000_0001, "state");
    wb(1'h1, ADDR_CIN1, 32'h0000_1A33);
    rdchk(ADDR_CIN1, 32'h0000_7F33, 32'h0000_1A33, "cin1");
    wb(1'h1, ADDR_LEVEL1, 32'h0000_1234);
    wb_sel_i <= 4'h2;
    wb(1'h1, ADDR_LEVEL1, 32'hABCD_5678);
    wb_sel_i <= 4'hF;
    rdchk(ADDR_LEVEL1, 32'hFFFF_FFFF, 32'h0000_5634, "byte lanes");
    wb(1'h0, 8'h40, 32'h0000_0000);
    chk("unmapped err", er, 1'h1);
    $display("test regs done");
  endtask
  task automatic t_remote();
    wb(1'h1, ADDR_CTRL, 32'h0000_0010);
    settle();
    chk("remote run", pump_run_o, 1'h1);
    field_model_i.set_ops(5'h02);
    settle();
    chk("degraded state", op_state_o, ST_LOCAL);
    chk("local no cond", pump_run_o, 1'h0);
    field_model_i.set_sw(4'h1);
    field_model_i.set_ops(5'h12);
    settle();
    chk("local run", pump_run_o, 1'h1);
    field_model_i.set_ops(5'h00);
    settle();
    chk("back remote", op_state_o, ST_REMOTE);
    $display("test remote done");
  endtask
  task automatic t_trip();
    field_model_i.set_ops(5'h01);
    settle();
    chk("trip out", trip_o, 1'h1);
    chk("trip stop", pump_run_o, 1'h0);
    field_model_i.set_ops(5'h05);
    settle();
    chk("bypass trip", trip_o, 1'h0);
    chk("bypass run", pump_run_o, 1'h1);
    field_model_i.set_ops(5'h00);
    $display("test trip done");
  endtask
  task automatic t_hyst();
    wb(1'h1, ADDR_LEVEL0, 32'h0000_03E8);
    wb(1'h1, ADDR_CIN0, 32'h0000_0A01);
    wb(1'h1, ADDR_CTRL, 32'h0000_0001);
    pv(16'h044C, 1'h0);
    pv(16'h044D, 1'h1);
    pv(16'h0384, 1'h1);
    wb(1'h1, ADDR_CIN0, 32'h0000_1401);
    pv(16'h0353, 1'h1);
    pv(16'h031F, 1'h0);
    field_model_i.set_ops(5'h02);
    pv(16'h04B1, 1'h1);
    chk("auto state", op_state_o, ST_AUTONOMOUS);
    wb(1'h1, ADDR_CIN0, 32'h0000_1421);
    settle();
    chk("chan two low", pump_run_o, 1'h0);
    field_model_i.set_pv(2, 16'h04B1);
    settle();
    chk("chan two high", pump_run_o, 1'h1);
    field_model_i.set_ops(5'h00);
    $display("test hysteresis done");
  endtask
  task automatic t_logic();
    logic e;
    wb(1'h1, ADDR_CIN0, 32'h0000_0012);
    wb(1'h1, ADDR_CIN1, 32'h0000_0020);
    for (int c = 0; c < 2; c++) begin
      wb(1'h1, ADDR_CTRL, c ? 32'h0000_000D : 32'h0000_0009);
      for (int s = 0; s < 4; s++) begin
        field_model_i.set_sw({1'h0, s[1:0], 1'h0});
        settle();
        e = c ? (!s[0] && s[1]) : (!s[0] || s[1]);
        chk("pv logic", pump_run_o, e);
      end
    end
    $display("test logic done");
  endtask
  task automatic t_override();
    wb(1'h1, ADDR_CIN0, 32'h0000_0000);
    wb(1'h1, ADDR_CTRL, 32'h0000_0001);
    field_model_i.set_sw(4'h0);
    field_model_i.set_ops(5'h18);
    settle();
    chk("override state", op_state_o, ST_LOCAL);
    chk("override no cond", pump_run_o, 1'h0);
    field_model_i.set_sw(4'h1);
    settle();
    chk("override run", pump_run_o, 1'h1);
    field_model_i.set_ops(5'h00);
    settle();
    chk("auto again", op_state_o, ST_AUTONOMOUS);
    wb(1'h1, ADDR_CTRL, 32'h0000_0002);
    settle();
    chk("local cfg", op_state_o, ST_LOCAL);
    chk("local idle", pump_run_o, 1'h0);
    field_model_i.set_ops(5'h10);
    settle();
    chk("local cond met", pump_run_o, 1'h1);
    field_model_i.set_sw(4'h0);
    settle();
    chk("local cond lost", pump_run_o, 1'h0);
    field_model_i.set_ops(5'h00);
    $display("test override done");
  endtask

  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'h0;
    t_regs();
    t_remote();
    t_trip();
    t_hyst();
    t_logic();
    t_override();
    results();
  end
endmodule
